// *** hdl/sacc_consts.vh ***
// constants for the converter control block
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
`define SACC_OFF_OFFSET 12'h2ec
`define SACC_OFF_CLKTRG 12'h30c
`define SACC_OFF_CTRL 12'h310
`define SACC_OFF_RES_LO 12'h314
`define SACC_OFF_RES_HI 12'h318
`define SACC_IDX_OFFSET 8'hbb
`define SACC_IDX_CLKTRG 8'hc3
`define SACC_IDX_CTRL 8'hc4
`define SACC_IDX_RES_LO 8'hc5
`define SACC_IDX_RES_HI 8'hc6
`define SACC_CTRL_ON 7
`define SACC_CTRL_CHMSB 5
`define SACC_CTRL_DONE 4
`define SACC_CTRL_GO 3
`define SACC_CFG_ALIGN 4
`define SACC_CTRL_RESET 8'h00
`define SACC_CFG_RESET 8'h00
`define SACC_OFS_RESET 5'h00
`define SACC_CONV_CLOCKS 30
`define SACC_TRG_SW 2'h0
`define SACC_TRG_T0 2'h1
`define SACC_TRG_FREE 2'h2
`define SACC_TRG_S3 2'h3
`define SACC_SETTLE_NS 5000
`define SACC_CLK_NS 25
`endif

// *** hdl/sacc_conversion_control.v ***
// converter control: registers, trigger, clock select, result formatting
`timescale 1ns/10ps
`default_nettype none
`include "sacc_consts.vh"
// How it works
// (R1) converter powered only while enabled
// (R2) software waits settling time before starting
// (R3) conversion lasts thirty converter clocks
// (R4) go starts; completion sets done, clears go in software mode only
// (R5) writing zero to go ignored
// (R6) no start without go; done blocks a start in software mode only
// (R7) result registers load with done flag
// (R8) left alignment: high byte, two in low
// (R9) right alignment: two in high, eight low
// (R10) unused result bits read zero
// (R11) trigger field selects start source
// (R12) repeated conversions in overflow or free modes
// (R13) clock field picks divider or overflow halved
// (R14) channel code steers input selector
// (R15) channel code built from bit five, two-zero
// (R16) done flag sticky until software clears
// (R17) software clears done before next request
// (R18) idle mode conversion completes and wakes
// (R19) no conversions during power-down
// (R20) signed offset added to each result
// (R21) overflow while busy is ignored
module sacc_conversion_control (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // system events, same clock
  input wire timer0_overflow,
  input wire timer4_overflow,
  input wire port3_baudgen_overflow,
  input wire power_down,
  input wire conv_irq_enable,
  // analog core
  output wire converter_power_on,
  output wire [3:0] input_selector,
  output reg sample_go,
  input wire [9:0] core_result,
  // processor side
  output wire conv_irq,
  output wire idle_wake
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  reg [7:0] ctrl_q;
  reg [7:0] cfg_q;
  reg [4:0] ofs_q;
  reg [7:0] res_hi_q;
  reg [7:0] res_lo_q;
  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg [4:0] div_q;
  reg half_q;
  reg tick;
  reg trig;
  reg [10:0] sum;
  reg [9:0] res;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire on = ctrl_q[`SACC_CTRL_ON];
  wire go = ctrl_q[`SACC_CTRL_GO];
  wire done = ctrl_q[`SACC_CTRL_DONE];
  wire [1:0] trg = cfg_q[1:0];
  wire [2:0] cks = cfg_q[7:5];
  wire finish = state_q == ST_CONV && tick &&
    cnt_q == 5'd`SACC_CONV_CLOCKS - 5'd1;
  wire mapped = paddr == `SACC_OFF_OFFSET || paddr == `SACC_OFF_CLKTRG ||
    paddr == `SACC_OFF_CTRL || paddr == `SACC_OFF_RES_LO ||
    paddr == `SACC_OFF_RES_HI;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  // (R1) power gate
  assign converter_power_on = on;
  // (R14) selector drive
  // (R15) channel assembly
  assign input_selector = {ctrl_q[`SACC_CTRL_CHMSB], ctrl_q[2:0]};
  // (R16) irq request
  // (R18) idle wake source
  assign conv_irq = done && conv_irq_enable;
  assign idle_wake = conv_irq;

  // divider taps, each a one-cycle enable at its rate
  reg [4:0] div_d;
  reg half_d;
  wire tap_div2 = div_q[0] == 1'b1;
  wire tap_div4 = div_q[1:0] == 2'h3;
  wire tap_div8 = div_q[2:0] == 3'h7;
  wire tap_div16 = div_q[3:0] == 4'hf;
  wire tap_div32 = div_q == 5'h1f;
  wire ovf_sel = (cks == 3'h6 && port3_baudgen_overflow) ||
    (cks == 3'h7 && timer4_overflow);

  // (R13) clock select
  always @* begin
    case (cks)
      3'h0: begin
        tick = 1'b1;
      end
      3'h1: begin
        tick = tap_div2;
      end
      3'h2: begin
        tick = tap_div4;
      end
      3'h3: begin
        tick = tap_div8;
      end
      3'h4: begin
        tick = tap_div16;
      end
      3'h5: begin
        tick = tap_div32;
      end
      3'h6: begin
        tick = port3_baudgen_overflow && half_q;
      end
      3'h7: begin
        tick = timer4_overflow && half_q;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // free-running divider: the first converter clock of a conversion
  // may be short, traded for not restarting the divider on each start
  // overflow clocks are halved by a toggle on the selected pulse
  always @* begin
    div_d = div_q + 5'h01;
    half_d = half_q;
    if (ovf_sel) begin
      half_d = !half_q;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 5'h00;
      half_q <= 1'b0;
    end else begin
      div_q <= div_d;
      half_q <= half_d;
    end
  end

  // (R11) trigger source
  // (R12) repeat while go
  // (R21) overflow pulse starts
  // software mode alone waits for done; the other modes ignore it
  always @* begin
    case (trg)
      `SACC_TRG_SW: begin
        trig = go && !done;
      end
      `SACC_TRG_T0: begin
        trig = go && timer0_overflow;
      end
      `SACC_TRG_FREE: begin
        trig = go;
      end
      `SACC_TRG_S3: begin
        trig = go && port3_baudgen_overflow;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end

  // offset is sign-extended; the sum wraps past ten bits
  wire [10:0] ofs_ext = {{6{ofs_q[4]}}, ofs_q};

  // (R20) offset add
  always @* begin
    sum = {1'b0, core_result} + ofs_ext;
    res = sum[9:0];
  end

  reg [1:0] state_d;
  reg [4:0] cnt_d;
  reg sample_go_d;
  wire abort = !on || power_down;
  wire start_ok = on && !power_down && trig &&
    (trg != `SACC_TRG_SW || !done);

  // sample_go is the core's one-cycle start strobe
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    sample_go_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // (R6) start gating
        // (R19) power-down blocks
        if (start_ok) begin
          state_d = ST_CONV;
          cnt_d = 5'h00;
          sample_go_d = 1'b1;
        end
      end
      ST_CONV: begin
        // (R3) thirty clocks
        // an abort drops the result and leaves done alone
        if (abort) begin
          state_d = ST_IDLE;
        end else if (finish) begin
          state_d = ST_IDLE;
        end else if (tick) begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 5'h00;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      sample_go <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sample_go <= sample_go_d;
    end
  end

  wire wr_ofs = wr && paddr == `SACC_OFF_OFFSET;
  wire wr_cfg = wr && paddr == `SACC_OFF_CLKTRG;
  wire wr_ctrl = wr && paddr == `SACC_OFF_CTRL;
  wire load_res = finish && on && !power_down;
  wire stop_cont = trg != `SACC_TRG_SW && wr_ctrl &&
    !pwdata[`SACC_CTRL_ON];
  reg [7:0] ctrl_d;
  reg [7:0] cfg_d;
  reg [4:0] ofs_d;
  reg [7:0] res_hi_d;
  reg [7:0] res_lo_d;

  // reserved bits stay zero whatever software writes
  always @* begin
    cfg_d = cfg_q;
    ofs_d = ofs_q;
    if (wr_cfg) begin
      cfg_d = {pwdata[7:4], 2'h0, pwdata[1:0]};
    end
    if (wr_ofs) begin
      ofs_d = pwdata[4:0];
    end
  end

  // continuous modes keep go set; done still records each result
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d[7] = pwdata[7];
      ctrl_d[5] = pwdata[5];
      ctrl_d[2:0] = pwdata[2:0];
      // (R16) software clears done
      if (!pwdata[`SACC_CTRL_DONE]) begin
        ctrl_d[`SACC_CTRL_DONE] = 1'b0;
      end
      // (R5) zero write ignored
      if (pwdata[`SACC_CTRL_GO]) begin
        ctrl_d[`SACC_CTRL_GO] = 1'b1;
      end
    end
    if (!on || stop_cont) begin
      ctrl_d[`SACC_CTRL_GO] = 1'b0;
    end
    // a completion wins over a clear in the same cycle
    if (load_res) begin
      // (R4) completion handshake
      ctrl_d[`SACC_CTRL_DONE] = 1'b1;
      if (trg == `SACC_TRG_SW) begin
        ctrl_d[`SACC_CTRL_GO] = 1'b0;
      end
    end
  end

  // (R7) result load
  // (R8) left alignment
  // (R9) right alignment
  // (R10) zero unused bits
  always @* begin
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    if (load_res) begin
      if (cfg_q[`SACC_CFG_ALIGN]) begin
        res_hi_d = {6'h00, res[9:8]};
        res_lo_d = res[7:0];
      end else begin
        res_hi_d = res[9:2];
        res_lo_d = {res[1:0], 6'h00};
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `SACC_CTRL_RESET;
      cfg_q <= `SACC_CFG_RESET;
      ofs_q <= `SACC_OFS_RESET;
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      ofs_q <= ofs_d;
      res_hi_q <= res_hi_d;
      res_lo_q <= res_lo_d;
    end
  end

  // read data is caught in the setup cycle and stands through access
  wire rd_setup = psel && !penable && !pwrite;
  wire [31:0] rd_ofs = {27'h0000000, ofs_q};
  wire [31:0] rd_cfg = {24'h000000, cfg_q};
  wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
  wire [31:0] rd_lo = {24'h000000, res_lo_q};
  wire [31:0] rd_hi = {24'h000000, res_hi_q};
  reg [31:0] prdata_d;

  always @* begin
    prdata_d = prdata;
    if (rd_setup) begin
      case (paddr)
        `SACC_OFF_OFFSET: begin
          prdata_d = rd_ofs;
        end
        `SACC_OFF_CLKTRG: begin
          prdata_d = rd_cfg;
        end
        `SACC_OFF_CTRL: begin
          prdata_d = rd_ctrl;
        end
        `SACC_OFF_RES_LO: begin
          prdata_d = rd_lo;
        end
        `SACC_OFF_RES_HI: begin
          prdata_d = rd_hi;
        end
        default: begin
          prdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_d;
    end
  end
endmodule // sacc_conversion_control
`default_nettype wire

// *** verification/sacc_core_model.sv ***
// analog core model
`timescale 1ns/10ps
`default_nettype none
module sacc_core_model (
  // core side
  input wire sys_clk, sample_go,
  input wire [3:0] input_selector,
  output logic [9:0] core_result = 10'h3ff
);
  always @(posedge sys_clk)
    if (sample_go) core_result <= {input_selector, 6'h15};
endmodule // sacc_core_model
`default_nettype wire

// *** verification/sacc_checker.sv ***
// port assertions for the converter control
`timescale 1ns/10ps
`default_nettype none
`include "sacc_consts.vh"
module sacc_checker (
  // watched ports
  input wire sys_clk, rst, psel, penable, pwrite, power_down, sample_go,
  input wire conv_irq_enable, converter_power_on, conv_irq, idle_wake,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] input_selector
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr;
    psel && penable && pwrite && paddr == `SACC_OFF_CTRL;
  endsequence
  a_power_bit: assert property (s_wr |=>
    converter_power_on == $past(pwdata[7])) else $error("power");
  a_chan_code: assert property (s_wr |=>
    {$past(pwdata[5]), $past(pwdata[2:0])} == input_selector)
    else $error("chan");
  a_go_on: assert property (sample_go |-> $past(converter_power_on))
    else $error("off");
  a_pd_idle: assert property ($past(power_down) |-> !sample_go)
    else $error("pd");
  a_go_gap: assert property (sample_go |=> !sample_go [*8])
    else $error("gap");
  a_irq_wake: assert property (conv_irq |-> idle_wake)
    else $error("wake");
  a_done_held: assert property ($fell(conv_irq) |->
    $past(penable) && $past(pwrite)) else $error("held");
  a_done_cause: assert property ($rose(conv_irq) |->
    $past(converter_power_on)) else $error("cause");
endmodule // sacc_checker
bind sacc_conversion_control sacc_checker sacc_checker_i (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .power_down(power_down), .sample_go(sample_go),
  .conv_irq_enable(conv_irq_enable),
  .converter_power_on(converter_power_on), .conv_irq(conv_irq),
  .idle_wake(idle_wake), .paddr(paddr), .pwdata(pwdata),
  .input_selector(input_selector));
`default_nettype wire

// *** verification/sacc_conversion_control_bench.sv ***
// self-checking bench for the converter control
`timescale 1ns/10ps
`default_nettype none
`include "sacc_consts.vh"
module sacc_conversion_control_bench;
  localparam [11:0] CT = `SACC_OFF_CTRL;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic timer0_overflow = 0, port3_baudgen_overflow = 0, power_down = 0;
  logic timer4_overflow = 0, conv_irq_enable = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [9:0] r;
  logic [7:0] c;
  logic err;
  wire pready, pslverr, converter_power_on, sample_go, conv_irq, idle_wake;
  wire [31:0] prdata;
  wire [3:0] input_selector;
  wire [9:0] core_result;
  int mismatches = 0, num_checks = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  sacc_conversion_control sacc_conversion_control_i (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer0_overflow(timer0_overflow),
    .timer4_overflow(timer4_overflow),
    .port3_baudgen_overflow(port3_baudgen_overflow),
    .power_down(power_down), .conv_irq_enable(conv_irq_enable),
    .converter_power_on(converter_power_on),
    .input_selector(input_selector), .sample_go(sample_go),
    .core_result(core_result), .conv_irq(conv_irq), .idle_wake(idle_wake));
  sacc_core_model sacc_core_model_i (
    .sys_clk(sys_clk), .sample_go(sample_go),
    .input_selector(input_selector), .core_result(core_result));
  // overflow pulses and a hang ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    timer0_overflow <= cyc % 40 == 0;
    port3_baudgen_overflow <= cyc % 40 == 7;
    timer4_overflow <= cyc % 40 == 20;
    if (cyc == 30000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic apb(input [11:0] a, input [31:0] d, input w);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b0;
  endtask
  task automatic chk(input [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input [11:0] a, input [31:0] e);
    apb(a, 0, 0);
    chk(rd, e);
  endtask
  // poll until done, bounded by the ceiling
  task automatic wdone;
    rd = 0;
    while (!rd[4]) apb(CT, 0, 0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    rc(CT, 0);
    chk(err, 0);
    rc(`SACC_OFF_CLKTRG, 0);
    rc(12'h004, 0);
    chk(err, 1);
    $display("reset test ended");
    // offsets +15, -16, -15; clock codes 0, 2, 4; both alignments
    for (int i = 0; i < 3; i++) begin
      c = {2'b10, i[1], 2'b0, i[0], 2'b11};
      r = 10'({c[5], c[2:0], 6'h15} + 15 + i - (i ? 32 : 0));
      apb(`SACC_OFF_OFFSET, 15 + i, 1);
      apb(`SACC_OFF_CLKTRG, {i[1:0], 1'b0, i[0], 4'h0}, 1);
      apb(CT, c, 1);
      @(negedge sys_clk);
      chk(input_selector, {c[5], c[2:0]});
      repeat (200) @(posedge sys_clk);
      apb(CT, c | 8, 1);
      apb(CT, c, 1);
      rc(CT, c | 8);
      wdone;
      chk(rd, c | 16);
      chk({idle_wake, conv_irq}, 2'b11);
      rc(`SACC_OFF_RES_HI, i[0] ? r[9:8] : r[9:2]);
      rc(`SACC_OFF_RES_LO, i[0] ? r[7:0] : {r[1:0], 6'h0});
      apb(CT, c, 1);
      repeat (99) @(posedge sys_clk);
      rc(CT, c);
      chk(conv_irq, 0);
      $display("manual test %0d ended", i);
    end
    // a start asked for in power-down never completes
    power_down <= 1;
    apb(CT, 8'h88, 1);
    repeat (99) @(posedge sys_clk);
    apb(CT, 0, 0);
    chk(rd, 32'h88);
    apb(CT, 0, 1);
    power_down <= 0;
    for (int t = 1; t < 4; t++) begin
      apb(`SACC_OFF_CLKTRG, t, 1);
      apb(CT, 8'h80, 1);
      repeat (200) @(posedge sys_clk);
      apb(CT, 8'h88, 1);
      wdone;
      apb(CT, 8'h88, 1);
      wdone;
      chk(rd, 8'h98);
      apb(CT, 0, 1);
      $display("trigger test %0d ended", t);
    end
    // overflow-halved clocks: thirty ticks take about 2400 cycles
    for (int k = 6; k < 8; k++) begin
      apb(`SACC_OFF_CLKTRG, k << 5, 1);
      apb(CT, 8'h80, 1);
      repeat (200) @(posedge sys_clk);
      apb(CT, 8'h88, 1);
      repeat (2000) @(posedge sys_clk);
      rc(CT, 8'h88);
      wdone;
      chk(rd, 8'h90);
      apb(CT, 0, 1);
      $display("halved clock test %0d ended", k);
    end
    final_report;
  end
endmodule // sacc_conversion_control_bench
`default_nettype wire
